// ===== rtl/pfg_override.sv
// port f/g alternate-function override logic with the special function register
// What this block does
// - test port on: tdi/tms/tck pull-up forced on, direction input, input disabled.
// - port f bits 3:0 have no overrides, only analog routing to channels 0-3.
// - legacy mode: g2:0 always present the memory strobes, never general i/o.
// - timer0 async select: g4 is oscillator input, pull-up off, input, no digital in.
// - timer0 async select: g3 is oscillator output, unusable as general i/o.
// - g4/g3 pull-up, direction, input-enable overrides follow async select, values zero.
// - ext memory on: g2 output, pull-up off, drives address latch strobe.
// - ext memory on: g1 output, pull-up off, drives read strobe.
// - ext memory on: g0 output, pull-up off, write strobe; input enable untouched.
// - global pull-up disable set kills every port pull-up not held by an override.
// - global pull-up disable is r/w at bit 2, resets to zero.
// - i/o offsets 0x00-0x3f; data space address is offset plus 0x20.
// - special function register at i/o 0x20 and data address 0x40.
// - tdo high impedance except in shifting test states.
// - test pin pull-ups stay on while reset is asserted.
`timescale 1ns/10ps
`default_nettype none
module pfg_override
  import pfg_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock, reset, enable
  input  wire logic             CLK,
  input  wire logic             SYS_RST,
  input  wire logic             CLK_EN,
  // core register access: io space or data space
  input  wire logic             IO_SEL,
  input  wire logic             DATA_SEL,
  input  wire logic [7:0]       ADDR,
  input  wire logic             WR_EN,
  input  wire logic             RD_EN,
  input  wire logic [7:0]       WDATA,
  output logic      [7:0]       RDATA,
  output logic                  RHIT,
  // mode controls from other blocks
  input  wire logic             TEST_PORT_ENABLE,
  input  wire logic             INSTR_SHIFT_STATE,
  input  wire logic             DATA_SHIFT_STATE,
  input  wire logic             SCAN_OUT,
  input  wire logic             TIMER0_ASYNC_SELECT,
  input  wire logic             EXT_MEM_ENABLE,
  input  wire logic             LEGACY_MODE,
  input  wire logic             ALE_STROBE,
  input  wire logic             RD_STROBE,
  input  wire logic             WR_STROBE,
  // generic port cell values, port f
  input  wire logic [WIDTH-1:0] PF_PIN_DIRECTION_BIT,
  input  wire logic [WIDTH-1:0] PF_PIN_OUTPUT_BIT,
  // generic port cell values, port g
  input  wire logic [WIDTH-1:0] PG_PIN_DIRECTION_BIT,
  input  wire logic [WIDTH-1:0] PG_PIN_OUTPUT_BIT,
  // effective pin controls, port f
  output logic      [WIDTH-1:0] PF_PULLUP,
  output logic      [WIDTH-1:0] PF_DIR,
  output logic      [WIDTH-1:0] PF_OUT,
  output logic      [WIDTH-1:0] PF_INPUT_EN,
  output logic      [WIDTH-1:0] PF_ANALOG_IO_PATH,
  // effective pin controls, port g
  output logic      [WIDTH-1:0] PG_PULLUP,
  output logic      [WIDTH-1:0] PG_DIR,
  output logic      [WIDTH-1:0] PG_OUT,
  output logic      [WIDTH-1:0] PG_INPUT_EN,
  output logic      [WIDTH-1:0] PG_ANALOG_IO_PATH,
  // global pull-up disable state
  output logic                  GLOBAL_PULLUP_DISABLE
);

  // register state
  logic global_pullup_disable_r;
  logic global_pullup_disable_nxt;
  logic sfio_hit;

  // address decode: io space as printed, data space shifted by bias
  function automatic logic sfio_match(input logic io, input logic dsp, input logic [7:0] a);
    logic m;
    m = 1'b0;
    if (io && a <= PFG_IO_SPACE_TOP && a[5:0] == PFG_IO_SFIO_OFS) begin
      m = 1'b1;
    end
    if (dsp && a == ({2'b00, PFG_IO_SFIO_OFS} + PFG_DATA_BIAS)) begin
      m = 1'b1;
    end
    return m;
  endfunction

  assign sfio_hit = sfio_match(IO_SEL, DATA_SEL, ADDR);

  // next value of the pull-up disable bit
  always_comb begin
    global_pullup_disable_nxt = global_pullup_disable_r;
    if (CLK_EN && WR_EN && sfio_hit) begin
      global_pullup_disable_nxt = WDATA[PFG_PUD_BIT];
    end
  end

  // register; clock enable low freezes it
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      global_pullup_disable_r <= PFG_PUD_RST;
    end else begin
      global_pullup_disable_r <= global_pullup_disable_nxt;
    end
  end

  // read path; other bits read zero
  always_comb begin
    RDATA = PFG_SFIO_RST;
    RHIT  = RD_EN && sfio_hit;
    if (RHIT) begin
      RDATA[PFG_PUD_BIT] = global_pullup_disable_r;
    end
  end

  assign GLOBAL_PULLUP_DISABLE = global_pullup_disable_r;

  // override vectors per port
  logic [WIDTH-1:0] f_pullup_override_enable, f_pullup_override_value, f_direction_override_enable, f_direction_override_value, f_port_value_override_enable, f_port_value_override_value, f_input_enable_override_enable, f_input_enable_override_value;
  logic [WIDTH-1:0] g_pullup_override_enable, g_pullup_override_value, g_direction_override_enable, g_direction_override_value, g_port_value_override_enable, g_port_value_override_value, g_input_enable_override_enable, g_input_enable_override_value;
  logic             shift_active;
  logic             mem_on;

  assign shift_active = INSTR_SHIFT_STATE || DATA_SHIFT_STATE;
  // legacy mode keeps port g bits 2:0 on their strobe functions
  assign mem_on = EXT_MEM_ENABLE || LEGACY_MODE;

  // port f override table; bits 3:0 stay zero
  always_comb begin
    f_pullup_override_enable  = '0;
    f_pullup_override_value  = '0;
    f_direction_override_enable  = '0;
    f_direction_override_value  = '0;
    f_port_value_override_enable  = '0;
    f_port_value_override_value  = '0;
    f_input_enable_override_enable = '0;
    f_input_enable_override_value = '0;
    if (TEST_PORT_ENABLE) begin
      f_pullup_override_enable[PFG_TDI_PIN]  = 1'b1;
      f_pullup_override_enable[PFG_TMS_PIN]  = 1'b1;
      f_pullup_override_enable[PFG_TCK_PIN]  = 1'b1;
      f_pullup_override_value[PFG_TDI_PIN]  = 1'b1;
      f_pullup_override_value[PFG_TMS_PIN]  = 1'b1;
      f_pullup_override_value[PFG_TCK_PIN]  = 1'b1;
      f_direction_override_enable[PFG_TDI_PIN]  = 1'b1;
      f_direction_override_enable[PFG_TMS_PIN]  = 1'b1;
      f_direction_override_enable[PFG_TCK_PIN]  = 1'b1;
      f_input_enable_override_enable[PFG_TDI_PIN] = 1'b1;
      f_input_enable_override_enable[PFG_TMS_PIN] = 1'b1;
      f_input_enable_override_enable[PFG_TCK_PIN] = 1'b1;
      f_pullup_override_enable[PFG_TDO_PIN]  = 1'b1;
      f_direction_override_enable[PFG_TDO_PIN]  = 1'b1;
      f_direction_override_value[PFG_TDO_PIN]  = shift_active;
      f_port_value_override_enable[PFG_TDO_PIN]  = 1'b1;
      f_port_value_override_value[PFG_TDO_PIN]  = SCAN_OUT;
      f_input_enable_override_enable[PFG_TDO_PIN] = 1'b1;
    end
  end

  // port g override table
  always_comb begin
    g_pullup_override_enable  = '0;
    g_pullup_override_value  = '0;
    g_direction_override_enable  = '0;
    g_direction_override_value  = '0;
    g_port_value_override_enable  = '0;
    g_port_value_override_value  = '0;
    g_input_enable_override_enable = '0;
    g_input_enable_override_value = '0;
    if (TIMER0_ASYNC_SELECT) begin
      g_pullup_override_enable[PFG_OSCI_PIN]  = 1'b1;
      g_direction_override_enable[PFG_OSCI_PIN]  = 1'b1;
      g_input_enable_override_enable[PFG_OSCI_PIN] = 1'b1;
      g_pullup_override_enable[PFG_OSCO_PIN]  = 1'b1;
      g_direction_override_enable[PFG_OSCO_PIN]  = 1'b1;
      g_input_enable_override_enable[PFG_OSCO_PIN] = 1'b1;
    end
    if (mem_on) begin
      g_pullup_override_enable[PFG_ALE_PIN] = 1'b1;
      g_direction_override_enable[PFG_ALE_PIN] = 1'b1;
      g_direction_override_value[PFG_ALE_PIN] = 1'b1;
      g_port_value_override_enable[PFG_ALE_PIN] = 1'b1;
      g_port_value_override_value[PFG_ALE_PIN] = ALE_STROBE;
      g_pullup_override_enable[PFG_RDS_PIN] = 1'b1;
      g_direction_override_enable[PFG_RDS_PIN] = 1'b1;
      g_direction_override_value[PFG_RDS_PIN] = 1'b1;
      g_port_value_override_enable[PFG_RDS_PIN] = 1'b1;
      g_port_value_override_value[PFG_RDS_PIN] = RD_STROBE;
      g_pullup_override_enable[PFG_WRS_PIN] = 1'b1;
      g_direction_override_enable[PFG_WRS_PIN] = 1'b1;
      g_direction_override_value[PFG_WRS_PIN] = 1'b1;
      g_port_value_override_enable[PFG_WRS_PIN] = 1'b1;
      g_port_value_override_value[PFG_WRS_PIN] = WR_STROBE;
    end
  end

  // mux one property: override wins where enabled
  function automatic logic [WIDTH-1:0] ovr(input logic [WIDTH-1:0] oe, input logic [WIDTH-1:0] ov,
                                           input logic [WIDTH-1:0] gen);
    return (oe & ov) | (~oe & gen);
  endfunction

  // generic pull-up request is input with output bit set; global disable
  // only gates pins not held by an override, so test pins keep their pull-ups
  function automatic logic [WIDTH-1:0] pull(input logic [WIDTH-1:0] oe, input logic [WIDTH-1:0] ov,
                                            input logic [WIDTH-1:0] dir, input logic [WIDTH-1:0] o,
                                            input logic dis);
    logic [WIDTH-1:0] gen;
    gen = ~dir & o & {WIDTH{~dis}};
    return ovr(oe, ov, gen);
  endfunction

  // pull-up path is combinational from overrides, so it holds through reset
  assign PF_PULLUP = pull(f_pullup_override_enable, f_pullup_override_value, PF_PIN_DIRECTION_BIT, PF_PIN_OUTPUT_BIT,
                          global_pullup_disable_r);
  assign PG_PULLUP = pull(g_pullup_override_enable, g_pullup_override_value, PG_PIN_DIRECTION_BIT, PG_PIN_OUTPUT_BIT,
                          global_pullup_disable_r);

  // direction, value, input enable
  assign PF_DIR      = ovr(f_direction_override_enable, f_direction_override_value, PF_PIN_DIRECTION_BIT);
  assign PF_OUT      = ovr(f_port_value_override_enable, f_port_value_override_value, PF_PIN_OUTPUT_BIT);
  assign PF_INPUT_EN = ovr(f_input_enable_override_enable, f_input_enable_override_value, {WIDTH{1'b1}});
  assign PG_DIR      = ovr(g_direction_override_enable, g_direction_override_value, PG_PIN_DIRECTION_BIT);
  assign PG_OUT      = ovr(g_port_value_override_enable, g_port_value_override_value, PG_PIN_OUTPUT_BIT);
  assign PG_INPUT_EN = ovr(g_input_enable_override_enable, g_input_enable_override_value, {WIDTH{1'b1}});

  // analog routing: port f all to converter, g4/g3 to oscillator when async
  assign PF_ANALOG_IO_PATH = {WIDTH{1'b1}};
  always_comb begin
    PG_ANALOG_IO_PATH = '0;
    PG_ANALOG_IO_PATH[PFG_OSCI_PIN] = TIMER0_ASYNC_SELECT;
    PG_ANALOG_IO_PATH[PFG_OSCO_PIN] = TIMER0_ASYNC_SELECT;
  end

  // assertions
  test_pins_a: assert property (@(posedge CLK)
    TEST_PORT_ENABLE |-> PF_PULLUP[PFG_TCK_PIN] && !PF_DIR[PFG_TMS_PIN] && !PF_INPUT_EN[PFG_TDI_PIN])
    else $error("test input pins not overridden");
  tdo_drive_a: assert property (@(posedge CLK)
    TEST_PORT_ENABLE |-> PF_DIR[PFG_TDO_PIN] == shift_active && PF_OUT[PFG_TDO_PIN] == SCAN_OUT)
    else $error("tdo drive wrong");
  tdo_float_a: assert property (@(posedge CLK)
    TEST_PORT_ENABLE && !shift_active |-> !PF_DIR[PFG_TDO_PIN] && !PF_PULLUP[PFG_TDO_PIN])
    else $error("tdo not floating");
  low_f_a: assert property (@(posedge CLK)
    PF_DIR[3:0] == PF_PIN_DIRECTION_BIT[3:0] && PF_OUT[3:0] == PF_PIN_OUTPUT_BIT[3:0])
    else $error("port f low pins overridden");
  osc_pins_a: assert property (@(posedge CLK)
    TIMER0_ASYNC_SELECT |-> !PG_PULLUP[PFG_OSCI_PIN] && !PG_DIR[PFG_OSCO_PIN] && !PG_INPUT_EN[PFG_OSCI_PIN])
    else $error("oscillator pins not overridden");
  mem_strobe_a: assert property (@(posedge CLK)
    mem_on |-> PG_DIR[2:0] == 3'h7 && PG_OUT[PFG_RDS_PIN] == RD_STROBE && PG_INPUT_EN[PFG_WRS_PIN])
    else $error("memory strobes not driven");
  pud_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    global_pullup_disable_r && !TEST_PORT_ENABLE |-> PF_PULLUP == '0)
    else $error("pull-up leaks while disabled");
  pud_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    CLK_EN && WR_EN && IO_SEL && !DATA_SEL && ADDR == 8'h20 |=> GLOBAL_PULLUP_DISABLE == $past(WDATA[2]))
    else $error("pull-up disable write lost");
  data_read_a: assert property (@(posedge CLK)
    RD_EN && DATA_SEL && !IO_SEL && ADDR == 8'h40 |-> RHIT && RDATA[PFG_PUD_BIT] == global_pullup_disable_r)
    else $error("data space read missed");

  // register update steps: a hitting write loads, anything else holds
  sequence pud_wr_s;
    CLK_EN && WR_EN && sfio_hit;
  endsequence
  sequence pud_idle_s;
    !(CLK_EN && WR_EN && sfio_hit);
  endsequence
  pud_load_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    pud_wr_s |=> global_pullup_disable_r == $past(WDATA[PFG_PUD_BIT]))
    else $error("pull-up disable load wrong");
  pud_freeze_a: assert property (@(posedge CLK) disable iff (SYS_RST)
    pud_idle_s |=> $stable(global_pullup_disable_r))
    else $error("pull-up disable moved without a write");
  pud_reset_a: assert property (@(posedge CLK)
    SYS_RST |=> !global_pullup_disable_r)
    else $error("pull-up disable not cleared by reset");

  // pin-side checks for test pin pull-ups in reset, the analog routes and strobes
  test_rst_pull_a: assert property (@(posedge CLK)
    TEST_PORT_ENABLE && SYS_RST |-> PF_PULLUP[PFG_TDI_PIN] && PF_PULLUP[PFG_TMS_PIN] && PF_PULLUP[PFG_TCK_PIN])
    else $error("test pin pull-ups dropped in reset");
  low_f_route_a: assert property (@(posedge CLK)
    PF_INPUT_EN[3:0] == 4'hf && PF_ANALOG_IO_PATH[3:0] == 4'hf)
    else $error("port f low pins not plain analog");
  osc_route_a: assert property (@(posedge CLK)
    TIMER0_ASYNC_SELECT |-> PG_ANALOG_IO_PATH[PFG_OSCI_PIN] && PG_ANALOG_IO_PATH[PFG_OSCO_PIN] && !PG_DIR[PFG_OSCI_PIN])
    else $error("oscillator route missing");
  legacy_alt_a: assert property (@(posedge CLK)
    LEGACY_MODE |-> PG_DIR[2:0] == 3'h7 && PG_OUT[PFG_ALE_PIN] == ALE_STROBE && PG_OUT[PFG_WRS_PIN] == WR_STROBE)
    else $error("legacy mode lets port g go general");
  mem_pull_a: assert property (@(posedge CLK)
    mem_on |-> PG_PULLUP[2:0] == 3'h0 && PG_OUT[PFG_ALE_PIN] == ALE_STROBE)
    else $error("memory strobe pins keep pull-ups");

endmodule
`default_nettype wire

// ===== rtl/pfg_pkg.sv
// package: offsets, fields and pin indices for the port f/g override block
package pfg_pkg;
  localparam logic [5:0] PFG_IO_SFIO_OFS   = 6'h20;  // dedicated i/o space offset
  localparam logic [7:0] PFG_DATA_BIAS    = 8'h20;  // data space = i/o offset + bias
  localparam logic [7:0] PFG_IO_SPACE_TOP = 8'h3f;  // last dedicated i/o offset
  localparam int         PFG_PUD_BIT      = 2;      // global pull-up disable field
  localparam logic       PFG_PUD_RST      = 1'b0;   // reset value of that field
  localparam logic [7:0] PFG_SFIO_RST     = 8'h00;  // register reset value
  // port f pins taken by the test port
  localparam int PFG_TDI_PIN = 7;
  localparam int PFG_TDO_PIN = 6;
  localparam int PFG_TMS_PIN = 5;
  localparam int PFG_TCK_PIN = 4;
  // port g pins
  localparam int PFG_OSCI_PIN = 4;
  localparam int PFG_OSCO_PIN = 3;
  localparam int PFG_ALE_PIN  = 2;
  localparam int PFG_RDS_PIN  = 1;
  localparam int PFG_WRS_PIN  = 0;
endpackage

// ===== test/pfg_board.sv
// board model: pads of port f driven by the block, pull-ups and floating lines
`timescale 1ns/10ps
`default_nettype none
module pfg_board (
  // clock
  input  wire logic       CLK,
  // pin controls from the block
  input  wire logic [7:0] DIR,
  input  wire logic [7:0] OUT,
  input  wire logic [7:0] PULLUP,
  // levels seen on the pads
  output logic      [7:0] PAD
);
  logic [7:0] last_r = 8'h00;
  // a floating pad toggles each cycle so a stale level never passes as driven
  always_comb PAD = (DIR & OUT) | (~DIR & PULLUP) | (~DIR & ~PULLUP & ~last_r);
  // remember the last level for the floating case
  always_ff @(posedge CLK) last_r <= PAD;
endmodule
`default_nettype wire

// ===== test/pfg_override_tb_top.sv
// testbench: pin overrides of ports f/g and the pull-up disable register
`timescale 1ns/10ps
`default_nettype none
module pfg_override_tb_top;
  import pfg_pkg::*;
  logic       clk, rst, cen, iosel, dsel, wr, rd, tpe, ish, dsh, sco, as0, ext_mem_enable, leg, ale, rds, wrs, rhit, gpd, hitv;
  logic [7:0] addr, wd, pfd, pfo, pgd, pgo, rdata, rdv, pad;
  logic [7:0] pfpu, pfdir, pfout, pfie, pgpu, pgdir, pgout, pgie, pfaio, pgaio;
  int         n_fail = 0;
  int         total_checks = 0;
  pfg_override i_pfg_override (.CLK(clk), .SYS_RST(rst), .CLK_EN(cen), .IO_SEL(iosel), .DATA_SEL(dsel),
    .ADDR(addr), .WR_EN(wr), .RD_EN(rd), .WDATA(wd), .RDATA(rdata), .RHIT(rhit), .TEST_PORT_ENABLE(tpe),
    .INSTR_SHIFT_STATE(ish), .DATA_SHIFT_STATE(dsh), .SCAN_OUT(sco), .TIMER0_ASYNC_SELECT(as0),
    .EXT_MEM_ENABLE(ext_mem_enable), .LEGACY_MODE(leg), .ALE_STROBE(ale), .RD_STROBE(rds), .WR_STROBE(wrs),
    .PF_PIN_DIRECTION_BIT(pfd), .PF_PIN_OUTPUT_BIT(pfo), .PG_PIN_DIRECTION_BIT(pgd), .PG_PIN_OUTPUT_BIT(pgo),
    .PF_PULLUP(pfpu), .PF_DIR(pfdir), .PF_OUT(pfout), .PF_INPUT_EN(pfie), .PF_ANALOG_IO_PATH(pfaio),
    .PG_PULLUP(pgpu), .PG_DIR(pgdir), .PG_OUT(pgout), .PG_INPUT_EN(pgie), .PG_ANALOG_IO_PATH(pgaio),
    .GLOBAL_PULLUP_DISABLE(gpd));
  pfg_board i_pfg_board (.CLK(clk), .DIR(pfdir), .OUT(pfout), .PULLUP(pfpu), .PAD(pad));
  // free-running clock, 8 ns period
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one register access, entered and left at a falling edge; read data sampled before the edge
  task automatic acc(input logic io, input logic [7:0] a, input logic w, input logic [7:0] d);
    iosel = io; dsel = ~io; addr = a; wr = w; rd = ~w; wd = d;
    #2 rdv = rdata; hitv = rhit;
    @(negedge clk);
    wr = 0; rd = 0; iosel = 0; dsel = 0;
  endtask
  task automatic t_reg;
    acc(1, 8'h20, 0, 0); chk(rdv, PFG_SFIO_RST, "reset value");
    acc(1, 8'h20, 1, 8'hff); chk({7'h0, gpd}, 8'h01, "io write");
    acc(0, 8'h40, 0, 0); chk(rdv, 8'h04, "data read");
    acc(1, 8'h40, 1, 8'h00); acc(0, 8'h20, 1, 8'h00); chk({7'h0, gpd}, 8'h01, "unmapped write");
    acc(1, 8'h3f, 0, 0); chk({rdv[7:1], hitv}, 8'h00, "unmapped read");
    cen = 0; acc(0, 8'h40, 1, 8'h00); cen = 1; chk({7'h0, gpd}, 8'h01, "frozen");
    acc(0, 8'h40, 1, 8'hfb); chk({7'h0, gpd}, 8'h00, "cleared");
  endtask
  task automatic t_pud;
    pfd = 8'h00; pfo = 8'hff; pgd = 8'h0f; pgo = 8'hff;
    for (int p = 0; p < 2; p++) begin
      acc(1, 8'h20, 1, p ? 8'h04 : 8'h00);
      chk(pfpu, p ? 8'h00 : 8'hff, "pf pullups");
      chk(pgpu, p ? 8'h00 : 8'hf0, "pg pullups");
      chk(pfie, 8'hff, "pf input en");
    end
  endtask
  // pud is still set here, so forced pull-ups must win over it
  task automatic t_test_port;
    pfd = 8'hff; pfo = 8'h00; tpe = 1;
    for (int i = 0; i < 3; i++) begin
      ish = (i == 1); dsh = (i == 2); sco = (i != 1);
      #1 chk(pfpu, 8'hb0, "tp pullups");
      chk(pfdir, {1'b0, i != 0, 6'h0f}, "tp dir");
      chk(pfie, 8'h0f, "tp input en");
      chk(pfout, {1'b0, sco, 6'h00}, "tp out");
      if (i != 0) chk({7'h0, pad[6]}, {7'h0, sco}, "tdo pad");
      @(negedge clk);
    end
    rst = 1;
    @(negedge clk);
    chk({pad[7], pad[5:4], gpd}, 4'he, "pads in reset");
    rst = 0; tpe = 0; ish = 0; dsh = 0;
  endtask
  task automatic t_port_g;
    pgd = 8'h00; pgo = 8'hff; {ale, rds, wrs} = 3'b101;
    for (int m = 0; m < 3; m++) begin
      as0 = (m == 0); ext_mem_enable = (m == 1); leg = (m == 2);
      #1 chk(pgpu, m ? 8'hf8 : 8'he7, "pg pullups");
      chk(pgdir, m ? 8'h07 : 8'h00, "pg dir");
      chk(pgie, m ? 8'hff : 8'he7, "pg input en");
      if (m) chk(pgout, 8'hfd, "pg strobes");
      @(negedge clk);
    end
    ext_mem_enable = 1; leg = 0; {ale, rds, wrs} = 3'b010;
    #1 chk(pgout, 8'hfa, "pg strobes flipped");
    @(negedge clk);
    pgd = 8'hff; ext_mem_enable = 0; as0 = 1;
    #1 chk(pgdir, 8'he7, "osc dir forced");
    chk(pgaio, 8'h18, "osc analog route");
    chk(pfaio, 8'hff, "pf analog route");
    @(negedge clk);
    as0 = 0;
    #1 chk(pgaio, 8'h00, "osc route off");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog, far beyond the few dozen cycles the tests need
  initial begin
    #20000;
    n_fail++;
    summarize();
  end
  // main sequence; io 0x20/0x3f/0x40 and data 0x20/0x40 are used, nothing extended
  initial begin
    rst = 1; cen = 1; iosel = 0; dsel = 0; addr = 0; wr = 0; rd = 0; wd = 0; tpe = 0; ish = 0; dsh = 0;
    sco = 0; as0 = 0; ext_mem_enable = 0; leg = 0; ale = 0; rds = 0; wrs = 0; pfd = 0; pfo = 0; pgd = 0; pgo = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 0;
    t_reg();
    t_pud();
    t_test_port();
    t_port_g();
    summarize();
  end
endmodule
`default_nettype wire
